// file: design/tcos_pkg.sv
package tcos_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int CHANNELS = 4;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_VALUE    = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_GATE     = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_POLARITY = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_MODE     = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_PIN      = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_IGNORED  = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions: channel n sits in bit n of every register
    localparam int FIELD_CHAN_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [CHANNELS-1:0] RST_VALUE    = 4'h0;
    localparam logic [CHANNELS-1:0] RST_GATE     = 4'h0;
    localparam logic [CHANNELS-1:0] RST_POLARITY = 4'h0;
    localparam logic [CHANNELS-1:0] RST_MODE     = 4'h0;
    localparam logic [CHANNELS-1:0] RST_IGNORED  = 4'h0;
    localparam logic [DATA_W-1:0]   RST_RDATA    = 8'h00;

    // Channel 0 is always a master, so its mode bit is fixed at zero
    localparam logic [CHANNELS-1:0] MODE_WRITABLE = 4'he;

    // Master interrupts that set each slave channel, four bits per channel
    localparam logic [4*CHANNELS-1:0] MASTER_MAP = 16'h4150;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic {
        MODE_INDEPENDENT = 1'b0,
        MODE_SLAVE       = 1'b1
    } tcos_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tcos_bus_req_t;

    typedef struct packed {
        logic gate;
        logic mode;
        logic polarity;
    } tcos_chan_cfg_t;

endpackage

// file: design/tcos_chan.sv
`timescale 1ns/100ps
module tcos_chan (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Configuration
    input  wire tcos_pkg::tcos_chan_cfg_t cfg,
    // Software write to the value bit
    input  wire logic                    sw_write,
    input  wire logic                    sw_data,
    // Timer events
    input  wire logic                    own_irq,
    input  wire logic                    master_irq,
    // Results
    output logic                         value,
    output logic                         pin
);

    logic next_value;
    logic next_pin;

    always_comb begin
        next_value = value;
        if (!cfg.gate) begin
            // Timer activity has no effect here; only software moves the bit
            if (sw_write) begin
                next_value = sw_data;
            end
        end else begin
            case (tcos_pkg::tcos_mode_t'(cfg.mode))
                tcos_pkg::MODE_INDEPENDENT: begin
                    if (own_irq) begin
                        next_value = ~value;
                    end
                end
                tcos_pkg::MODE_SLAVE: begin
                    // Set wins when master and slave fire together
                    if (master_irq) begin
                        next_value = 1'b1;
                    end else if (own_irq) begin
                        next_value = 1'b0;
                    end
                end
                default: begin
                    next_value = value;
                end
            endcase
        end
        // Value 1 is the active state; polarity picks its level on the pin
        next_pin = cfg.polarity ? ~next_value : next_value;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value <= 1'b0;
            pin   <= 1'b0;
        end else begin
            value <= next_value;
            pin   <= next_pin;
        end
    end

endmodule

// file: design/tcos_top.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module tcos_top (
    // Clock and reset
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    // Register port
    input  wire tcos_pkg::tcos_bus_req_t          bus_req,
    output logic [tcos_pkg::DATA_W-1:0]           rd_data,
    // Timer channel interrupt requests, one-cycle pulses
    input  wire logic [tcos_pkg::CHANNELS-1:0]    chan_irq,
    // Timer output pins
    output logic [tcos_pkg::CHANNELS-1:0]         pin_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding

    function automatic logic write_hit(
        input tcos_pkg::tcos_bus_req_t req,
        input logic [tcos_pkg::ADDR_W-1:0] off
    );
        write_hit = req.wr && (req.addr == off);
    endfunction

    function automatic logic [tcos_pkg::DATA_W-1:0] widen(
        input logic [tcos_pkg::CHANNELS-1:0] bits
    );
        // Bits above the channels always read as zero
        widen = {{(tcos_pkg::DATA_W - tcos_pkg::CHANNELS){1'b0}}, bits};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [tcos_pkg::CHANNELS-1:0] gate;
    logic [tcos_pkg::CHANNELS-1:0] polarity;
    logic [tcos_pkg::CHANNELS-1:0] mode;
    logic [tcos_pkg::CHANNELS-1:0] ignored;
    logic [tcos_pkg::CHANNELS-1:0] next_gate;
    logic [tcos_pkg::CHANNELS-1:0] next_polarity;
    logic [tcos_pkg::CHANNELS-1:0] next_mode;
    logic [tcos_pkg::CHANNELS-1:0] next_ignored;
    logic [tcos_pkg::DATA_W-1:0]   next_rd_data;

    logic [tcos_pkg::CHANNELS-1:0] value;
    logic [tcos_pkg::CHANNELS-1:0] chan_pin;
    logic [tcos_pkg::CHANNELS-1:0] value_write;
    logic [tcos_pkg::CHANNELS-1:0] value_refused;
    logic [tcos_pkg::CHANNELS-1:0] master_irq;
    logic [tcos_pkg::CHANNELS-1:0] wdata_chan;

    assign wdata_chan = bus_req.wdata[tcos_pkg::FIELD_CHAN_LSB +: tcos_pkg::CHANNELS];

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_comb begin
        next_gate     = gate;
        next_polarity = polarity;
        next_mode     = mode;
        if (write_hit(bus_req, tcos_pkg::OFF_GATE)) begin
            next_gate = wdata_chan;
        end
        if (write_hit(bus_req, tcos_pkg::OFF_POLARITY)) begin
            next_polarity = wdata_chan;
        end
        if (write_hit(bus_req, tcos_pkg::OFF_MODE)) begin
            next_mode = wdata_chan & tcos_pkg::MODE_WRITABLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate     <= tcos_pkg::RST_GATE;
            polarity <= tcos_pkg::RST_POLARITY;
            mode     <= tcos_pkg::RST_MODE;
        end else begin
            gate     <= next_gate;
            polarity <= next_polarity;
            mode     <= next_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Value writes: accepted only where the gate is off

    always_comb begin
        value_write   = '0;
        value_refused = '0;
        if (write_hit(bus_req, tcos_pkg::OFF_VALUE)) begin
            // The gate seen is the one already in force, not one written now
            value_write   = ~gate;
            value_refused = gate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Refused-write flags, cleared by writing ones

    always_comb begin
        next_ignored = ignored;
        if (write_hit(bus_req, tcos_pkg::OFF_IGNORED)) begin
            next_ignored = ignored & ~wdata_chan;
        end
        // A refusal in the clearing cycle is kept
        next_ignored = next_ignored | value_refused;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ignored <= tcos_pkg::RST_IGNORED;
        end else begin
            ignored <= next_ignored;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channels

    genvar n;
    generate
        for (n = 0; n < tcos_pkg::CHANNELS; n++) begin : g_chan
            tcos_pkg::tcos_chan_cfg_t cfg;

            // Any master listed for this channel may set it in slave mode
            assign master_irq[n] =
                |(chan_irq & tcos_pkg::MASTER_MAP[4*n +: tcos_pkg::CHANNELS]);
            assign cfg.gate     = gate[n];
            assign cfg.mode     = mode[n];
            assign cfg.polarity = polarity[n];

            tcos_chan u_chan (
                .clock      (clock),
                .rst_n      (rst_n),
                .cfg        (cfg),
                .sw_write   (value_write[n]),
                .sw_data    (wdata_chan[n]),
                .own_irq    (chan_irq[n]),
                .master_irq (master_irq[n]),
                .value      (value[n]),
                .pin        (chan_pin[n])
            );
        end
    endgenerate

    // Pins come straight from the channel flops
    assign pin_out = chan_pin;

    ////////////////////////////////////////////////////////////////////////////////
    // Read port

    always_comb begin
        next_rd_data = tcos_pkg::RST_RDATA;
        if (bus_req.rd) begin
            case (bus_req.addr)
                tcos_pkg::OFF_VALUE: begin
                    next_rd_data = widen(value);
                end
                tcos_pkg::OFF_GATE: begin
                    next_rd_data = widen(gate);
                end
                tcos_pkg::OFF_POLARITY: begin
                    next_rd_data = widen(polarity);
                end
                tcos_pkg::OFF_MODE: begin
                    next_rd_data = widen(mode);
                end
                tcos_pkg::OFF_PIN: begin
                    next_rd_data = widen(chan_pin);
                end
                tcos_pkg::OFF_IGNORED: begin
                    next_rd_data = widen(ignored);
                end
                default: begin
                    // Unmapped offsets read as zero
                    next_rd_data = tcos_pkg::RST_RDATA;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= tcos_pkg::RST_RDATA;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule

// file: sim/tcos_pin_obs.sv
`timescale 1ns/100ps
module tcos_pin_obs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Pins seen from the board side
    input  wire logic [3:0]  pins,
    output logic [3:0][7:0]  rises
);
    logic [3:0] last;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last  <= '0;
            rises <= '0;
        end else begin
            last <= pins;
            for (int i = 0; i < 4; i++) begin
                rises[i] <= rises[i] + 8'(pins[i] & ~last[i]);
            end
        end
    end
endmodule

// file: sim/tcos_top_monitor.sv
`timescale 1ns/100ps
module tcos_top_monitor (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // Watched ports
    input  wire tcos_pkg::tcos_bus_req_t     bus_req,
    input  wire logic [tcos_pkg::DATA_W-1:0] rd_data,
    input  wire logic [3:0]                  chan_irq,
    input  wire logic [3:0]                  pin_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of the always-writable settings
    logic [3:0] gate, pol, mode, next_gate, next_pol, next_mode, set;
    logic       wr_g, wr_p, wr_m, wr_v, rd_v;
    assign wr_g = bus_req.wr && bus_req.addr == tcos_pkg::OFF_GATE;
    assign wr_p = bus_req.wr && bus_req.addr == tcos_pkg::OFF_POLARITY;
    assign wr_m = bus_req.wr && bus_req.addr == tcos_pkg::OFF_MODE;
    assign wr_v = bus_req.wr && bus_req.addr == tcos_pkg::OFF_VALUE;
    assign rd_v = bus_req.rd && bus_req.addr == tcos_pkg::OFF_VALUE;
    // Master requests per slave channel
    assign set = {chan_irq[2], chan_irq[0], chan_irq[0] | chan_irq[2], 1'b0};
    always_comb begin
        next_gate = wr_g ? bus_req.wdata[3:0] : gate;
        next_pol  = wr_p ? bus_req.wdata[3:0] : pol;
        next_mode = wr_m ? bus_req.wdata[3:0] & tcos_pkg::MODE_WRITABLE : mode;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {gate, pol, mode} <= '0;
        end else begin
            {gate, pol, mode} <= {next_gate, next_pol, next_mode};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // A polarity write lands one cycle late, so a write just before is excluded
    AST_PIN_READ: assert property (
        bus_req.rd && bus_req.addr == tcos_pkg::OFF_PIN |=> rd_data == {4'h0, $past(pin_out)})
        else $error("pin readback wrong");
    AST_HOLD: assert property (
        chan_irq != 4'h0 && !bus_req.wr && !$past(bus_req.wr)
        |=> ((pin_out ^ $past(pin_out)) & ~gate) == 4'h0) else $error("ungated pin moved");
    AST_SW_WRITE: assert property (
        wr_v && !$past(bus_req.wr) |=> ((pin_out ^ pol ^ $past(bus_req.wdata[3:0])) & ~gate)
        == 4'h0) else $error("written level not on pin");
    AST_SW_IGNORE: assert property (
        wr_v && chan_irq == 4'h0 && !$past(bus_req.wr)
        |=> ((pin_out ^ $past(pin_out)) & gate) == 4'h0) else $error("gated write took");
    AST_POS: assert property (
        rd_v && !$past(bus_req.wr) |=> ((rd_data[3:0] ^ $past(pin_out)) & ~pol) == 4'h0)
        else $error("positive pin wrong");
    AST_NEG: assert property (
        rd_v && !$past(bus_req.wr) |=> ((rd_data[3:0] ^ ~$past(pin_out)) & pol) == 4'h0)
        else $error("inverted pin wrong");
    AST_TOGGLE: assert property (
        chan_irq != 4'h0 && !bus_req.wr && !$past(bus_req.wr)
        |=> (((pin_out ^ $past(pin_out)) ^ ($past(chan_irq) & gate)) & ~mode) == 4'h0)
        else $error("toggle wrong");
    AST_SLAVE: assert property (
        chan_irq != 4'h0 && !bus_req.wr && !$past(bus_req.wr)
        |=> ((pin_out ^ pol ^ $past(set)) & gate & mode & ($past(set) | $past(chan_irq)))
        == 4'h0) else $error("slave set or clear wrong");
endmodule
bind tcos_top tcos_top_monitor mon (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
    .rd_data(rd_data), .chan_irq(chan_irq), .pin_out(pin_out));

// file: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic                    clock;
    logic                    rst_n;
    tcos_pkg::tcos_bus_req_t bus_req;
    logic [7:0]              rd_data;
    logic [3:0]              chan_irq;
    logic [3:0]              pin_out;
    logic [3:0][7:0]         rises;
    int                      fail_count;
    int                      checked;
    int                      cyc;

    tcos_top dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
        .chan_irq(chan_irq), .pin_out(pin_out));
    tcos_pin_obs obs (.clock(clock), .rst_n(rst_n), .pins(pin_out), .rises(rises));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= {a, d, 2'b10};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1;
        chk($sformatf("reg %0d", a), rd_data, exp);
    endtask
    task automatic irq(input logic [3:0] m);
        @(posedge clock);
        chan_irq <= m;
        @(posedge clock);
        chan_irq <= 4'h0;
    endtask
    task automatic tally_and_finish;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Whole run needs well under 300 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        chan_irq = 4'h0;
        fail_count = 0;
        checked = 0;
        cyc = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), 8'h00);
        end
        wr(tcos_pkg::OFF_VALUE, 8'hf5);
        rd(tcos_pkg::OFF_PIN, 8'h05);
        rd(tcos_pkg::OFF_VALUE, 8'h05);
        irq(4'hf);
        rd(tcos_pkg::OFF_PIN, 8'h05);
        wr(tcos_pkg::OFF_POLARITY, 8'h03);
        rd(tcos_pkg::OFF_PIN, 8'h06);
        wr(tcos_pkg::OFF_GATE, 8'h0f);
        wr(tcos_pkg::OFF_VALUE, 8'h00);
        rd(tcos_pkg::OFF_VALUE, 8'h05);
        irq(4'h1);
        rd(tcos_pkg::OFF_VALUE, 8'h04);
        rd(tcos_pkg::OFF_PIN, 8'h07);
        wr(tcos_pkg::OFF_MODE, 8'hff);
        rd(tcos_pkg::OFF_MODE, 8'h0e);
        irq(4'h1);
        rd(tcos_pkg::OFF_VALUE, 8'h07);
        irq(4'h2);
        rd(tcos_pkg::OFF_VALUE, 8'h05);
        irq(4'h6);
        rd(tcos_pkg::OFF_VALUE, 8'h0b);
        rd(tcos_pkg::OFF_PIN, 8'h08);
        rd(tcos_pkg::OFF_IGNORED, 8'h0f);
        wr(tcos_pkg::OFF_IGNORED, 8'h05);
        rd(tcos_pkg::OFF_IGNORED, 8'h0a);
        chk("rises0", rises[0], 8'h02);
        chk("rises1", rises[1], 8'h02);
        chk("rises2", rises[2], 8'h01);
        chk("rises3", rises[3], 8'h01);
        // Mid-run reset must bring every value bit and pin back to zero
        rst_n <= 1'b0;
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(tcos_pkg::OFF_PIN, 8'h00);
        rd(tcos_pkg::OFF_VALUE, 8'h00);
        tally_and_finish();
    end
endmodule
